// ### hdl/fcr_loop.sv
`timescale 1ns/1ps
// Internal data path with loopback and link forcing
module fcr_loop (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  fcr_lb_if.dp lb, // Control from register bank
  input wire logic [7:0] host_txd_i, // Internal transmit data
  input wire logic host_tx_en_i, // Internal transmit enable
  input wire logic [7:0] line_rxd_i, // Line receive data
  input wire logic line_rx_dv_i, // Line receive valid
  input wire logic line_link_i, // Line link from media side
  output logic [7:0] host_rxd_o, // Internal receive data
  output logic host_rx_dv_o, // Internal receive valid
  output logic [7:0] line_txd_o, // Line transmit data
  output logic line_tx_en_o, // Line transmit enable
  output logic link_up_o, // Reported line link
  output logic [1:0] loop_rate_o // Rate used by loopback
);

  logic [7:0] next_rxd; // Next receive data
  logic next_rx_dv; // Next receive valid
  logic [7:0] next_txd; // Next line data
  logic next_tx_en; // Next line enable
  logic next_link; // Next link state
  logic [1:0] next_rate; // Next loop rate

  // Steer data between host and line
  always_comb begin
    next_rate = lb.lb_rate;
    // RULE4: link held down
    next_link = line_link_i & ~lb.loop_en & ~lb.link_hold;
    if (lb.loop_en) begin
      // RULE3: transmit returned inward
      next_rxd = host_txd_i;
      next_rx_dv = host_tx_en_i;
      next_txd = 8'h00;
      next_tx_en = 1'b0;
    end else begin
      // Normal pass-through
      next_rxd = line_rxd_i;
      next_rx_dv = line_rx_dv_i;
      next_txd = host_txd_i;
      next_tx_en = host_tx_en_i;
    end
    if (rst_i) begin
      next_rxd = 8'h00;
      next_rx_dv = 1'b0;
      next_txd = 8'h00;
      next_tx_en = 1'b0;
      next_link = 1'b0;
      next_rate = 2'h0;
    end
  end

  // Output flops
  always_ff @(posedge clk_i) begin
    host_rxd_o <= next_rxd;
    host_rx_dv_o <= next_rx_dv;
    line_txd_o <= next_txd;
    line_tx_en_o <= next_tx_en;
    link_up_o <= next_link;
    loop_rate_o <= next_rate;
  end

endmodule : fcr_loop

// ### hdl/fcr_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for the strap pins
module fcr_sync (
  input wire logic clk_i, // System clock
  input wire logic [1:0] d_i, // Asynchronous pin levels
  output logic [1:0] q_o // Synchronised levels
);

  logic [1:0] meta; // First stage, read only by the second
  logic [1:0] next_meta; // Next first stage
  logic [1:0] next_q; // Next second stage

  // Shift pins through both stages
  always_comb begin
    next_meta = d_i;
    next_q = meta;
  end

  // Stages are not reset so straps settle while reset is held
  always_ff @(posedge clk_i) begin
    meta <= next_meta;
    q_o <= next_q;
  end

endmodule : fcr_sync

// ### hdl/fcr_top.sv
// Operation
// RULE1: Writing reset bit resets fiber-side state
// RULE2: Reset bit clears itself when done
// RULE3: Loopback returns transmit data to receive
// RULE4: Loopback forces line link down
// RULE5: Loopback rate follows media mode
// RULE6: Speed bits encoding; modes 00/01 force
// RULE7: Select 10 shows live speed, read-only
// RULE8: Select 11 makes speed bits writable
// RULE9: Enable change breaks link, restarts negotiation
// RULE10: Enable ignored in 100BASE-FX mode; an enable change there still holds link_up_o low for one cycle via link_hold
// RULE11: Hardware reset loads enable from strap
// RULE12: Power-down exit resets and restarts negotiation
// RULE13: Power-down reset value is strap and mode
// RULE14: Restart after resets, change or write
// RULE15: Duplex applies only at listed events
// RULE16: Isolate bit reads zero, read-only
// RULE17: Collision test reads zero, no effect
// RULE18: Reserved low bits read zero
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "fcr_consts.svh"
module fcr_top
  import fcr_pkg::*;
(
  input wire logic clk_i, // System clock, 40 MHz
  input wire logic rst_i, // Synchronous reset, high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Bus acknowledge
  input wire logic autoneg_strap_i, // Negotiation strap pin
  input wire logic powerdown_strap_i, // Power-down strap pin
  input wire logic [2:0] op_sel_i, // Media operating select
  input wire logic [1:0] live_speed_i, // Live speed code
  input wire logic [7:0] host_txd_i, // Internal transmit data
  input wire logic host_tx_en_i, // Internal transmit enable
  input wire logic [7:0] line_rxd_i, // Line receive data
  input wire logic line_rx_dv_i, // Line receive valid
  input wire logic line_link_i, // Line link status
  output logic [7:0] host_rxd_o, // Internal receive data
  output logic host_rx_dv_o, // Internal receive valid
  output logic [7:0] line_txd_o, // Line transmit data
  output logic line_tx_en_o, // Line transmit enable
  output logic link_up_o, // Reported link
  output logic [1:0] loop_rate_o, // Loopback rate code
  output logic fiber_reset_o, // Fiber state machines in reset
  output logic an_restart_o, // Negotiation restart pulse
  output logic an_enable_o, // Effective negotiation enable
  output logic link_break_o, // Link break pulse
  output logic duplex_o, // Effective duplex, 1 full
  output logic powerdown_o, // Port powered down
  output logic [1:0] speed_o // Effective speed code
);

  // Speed bits as seen by software and logic
  function automatic logic [1:0] fcr_speed_view(
    input logic [1:0] mode,
    input logic [1:0] live,
    input logic [1:0] rw
  );
    logic [1:0] v;
    v = rw;
    unique case (mode)
      // RULE6: forced speed codes
      `FCR_MODE_FX: v = fcr_spd_100;
      `FCR_MODE_BX: v = fcr_spd_1000;
      // RULE7: live speed shown
      `FCR_MODE_SG: v = {live == fcr_spd_1000, live == fcr_spd_100};
      // RULE8: software value
      `FCR_MODE_RW: v = rw;
    endcase
    return v;
  endfunction : fcr_speed_view

  // Modes in which power-down may come from the strap
  function automatic logic fcr_pd_mode(input logic [2:0] m);
    return m[1] | (m == 3'h4);
  endfunction : fcr_pd_mode

  logic [1:0] straps; // Synchronised straps
  logic [1:0] mode; // Low select bits
  logic fx_mode; // 100BASE-FX active
  fcr_state_t state; // Reset sequencer state
  fcr_state_t next_state; // Next sequencer state
  logic [`FCR_CNT_W-1:0] cnt; // Reset cycle counter
  logic [`FCR_CNT_W-1:0] next_cnt; // Next counter
  logic loop; // Loopback bit
  logic next_loop; // Next loopback
  logic an_en; // Negotiation enable bit
  logic next_an_en; // Next enable
  logic powerdown_strap; // Power-down bit
  logic next_powerdown_strap; // Next power-down
  logic [1:0] spd_rw; // Software speed bits
  logic [1:0] next_spd_rw; // Next software speed
  logic dup_wr; // Written duplex
  logic next_dup_wr; // Next written duplex
  logic dup; // Effective duplex
  logic next_dup; // Next effective duplex
  logic restart; // Restart bit, one cycle
  logic next_restart; // Next restart
  logic brk; // Link break pulse
  logic next_brk; // Next break
  logic rst_q; // Reset seen last cycle
  logic next_rst_q; // Next reset history
  logic [1:0] spd_q; // Registered speed
  logic [1:0] next_spd_q; // Next speed
  logic ack; // Bus acknowledge
  logic next_ack; // Next acknowledge
  logic [31:0] rdat; // Read data
  logic [31:0] next_rdat; // Next read data
  logic hit; // Address hits control word
  logic wr_hi; // Write to upper byte
  logic wr_lo; // Write to lower byte
  logic [15:0] rd_val; // Control word image
  logic [1:0] spd_view; // Speed bits view
  logic sw_go; // Start software reset
  logic an_go; // Start negotiation restart
  logic [15:0] wd; // Write data, low half

  // Strap pins pass two flops
  fcr_sync u_sync (
    .clk_i(clk_i),
    .d_i({autoneg_strap_i, powerdown_strap_i}),
    .q_o(straps)
  );

  fcr_lb_if lb_if ();

  // Data path with loopback
  fcr_loop u_loop (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lb(lb_if.dp),
    .host_txd_i(host_txd_i),
    .host_tx_en_i(host_tx_en_i),
    .line_rxd_i(line_rxd_i),
    .line_rx_dv_i(line_rx_dv_i),
    .line_link_i(line_link_i),
    .host_rxd_o(host_rxd_o),
    .host_rx_dv_o(host_rx_dv_o),
    .line_txd_o(line_txd_o),
    .line_tx_en_o(line_tx_en_o),
    .link_up_o(link_up_o),
    .loop_rate_o(loop_rate_o)
  );

  // Mode decode and bus qualifiers
  assign mode = op_sel_i[1:0];
  assign fx_mode = (mode == `FCR_MODE_FX);
  assign wd = wb_dat_i[15:0];
  assign hit = (wb_adr_i[7:2] == `FCR_ADR_CTRL);
  assign wr_hi = wb_cyc_i & wb_stb_i & wb_we_i & ack & hit & wb_sel_i[1];
  assign wr_lo = wb_cyc_i & wb_stb_i & wb_we_i & ack & hit & wb_sel_i[0];
  assign spd_view = fcr_speed_view(mode, live_speed_i, spd_rw);

  // Control word as read back
  always_comb begin
    rd_val = 16'h0000;
    rd_val[`FCR_B_SWRST] = (state == fcr_st_swrst);
    rd_val[`FCR_B_LOOP] = loop;
    rd_val[`FCR_B_SPD_LSB] = spd_view[0];
    rd_val[`FCR_B_ANEN] = an_en;
    rd_val[`FCR_B_POWERDOWN_STRAP] = powerdown_strap;
    // RULE16: isolate reads zero
    rd_val[`FCR_B_ISO] = 1'b0;
    rd_val[`FCR_B_RESTART] = restart;
    rd_val[`FCR_B_DUPLEX] = dup_wr;
    // RULE17: collision test zero
    rd_val[`FCR_B_COLT] = 1'b0;
    rd_val[`FCR_B_SPD_MSB] = spd_view[1];
    // RULE18: low bits stay zero
    rd_val[5:0] = 6'h00;
  end

  // Bus slave: ack one cycle after request, unmapped reads zero
  always_comb begin
    next_ack = wb_cyc_i & wb_stb_i & ~ack & ~rst_i;
    next_rdat = rdat;
    if (wb_cyc_i & wb_stb_i & ~ack) begin
      next_rdat = hit ? {16'h0000, rd_val} : 32'h0000_0000;
    end
    if (rst_i) begin
      next_rdat = 32'h0000_0000;
    end
  end

  // Control bits, reset sequencer and events
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_loop = loop;
    next_an_en = an_en;
    next_powerdown_strap = powerdown_strap;
    next_spd_rw = spd_rw;
    next_dup_wr = dup_wr;
    next_dup = dup;
    next_restart = 1'b0;
    next_brk = 1'b0;
    next_rst_q = rst_i;
    next_spd_q = spd_view;
    sw_go = 1'b0;
    an_go = 1'b0;
    // RULE14: restart after hardware reset
    if (rst_q & ~rst_i) begin
      an_go = 1'b1;
    end
    // Upper byte write
    if (wr_hi) begin
      next_loop = wd[`FCR_B_LOOP];
      next_an_en = wd[`FCR_B_ANEN];
      next_powerdown_strap = wd[`FCR_B_POWERDOWN_STRAP];
      next_dup_wr = wd[`FCR_B_DUPLEX];
      // RULE1: write one starts reset
      if (wd[`FCR_B_SWRST]) begin
        sw_go = 1'b1;
      end
      // RULE14: restart on written one
      if (wd[`FCR_B_RESTART]) begin
        an_go = 1'b1;
      end
      // RULE9: enable change breaks link
      if (wd[`FCR_B_ANEN] != an_en) begin
        an_go = 1'b1;
        next_brk = 1'b1;
      end
      // RULE12: leaving power-down resets
      if (powerdown_strap & ~wd[`FCR_B_POWERDOWN_STRAP]) begin
        sw_go = 1'b1;
        an_go = 1'b1;
      end
      // RULE8: writable speed LSB
      if (mode == `FCR_MODE_RW) begin
        next_spd_rw[0] = wd[`FCR_B_SPD_LSB];
      end
    end
    // Lower byte write, only speed MSB is writable
    if (wr_lo & (mode == `FCR_MODE_RW)) begin
      next_spd_rw[1] = wd[`FCR_B_SPD_MSB];
    end
    // RULE1: fiber reset sequence
    if (sw_go) begin
      next_state = fcr_st_swrst;
      next_cnt = `FCR_CNT_W'(`FCR_SWRST_CYC - 1);
      next_loop = 1'b0;
      next_powerdown_strap = 1'b0;
      an_go = 1'b1;
    end else begin
      unique case (state)
        fcr_st_run: next_cnt = cnt;
        // RULE2: self-clear when done
        fcr_st_swrst: begin
          if (cnt == '0) begin
            next_state = fcr_st_run;
          end else begin
            next_cnt = cnt - `FCR_CNT_W'(1);
          end
        end
      endcase
    end
    // RULE14: restart bit set, clears itself
    if (an_go) begin
      next_restart = 1'b1;
    end
    // RULE15: duplex applied at events
    if (sw_go | an_go) begin
      next_dup = next_dup_wr;
    end
    // Hardware reset values
    if (rst_i) begin
      next_state = fcr_st_run;
      next_cnt = '0;
      next_loop = `FCR_RST_LOOP;
      // RULE11: enable from strap
      next_an_en = straps[1];
      // RULE13: power-down from strap
      next_powerdown_strap = straps[0] & fcr_pd_mode(op_sel_i);
      next_spd_rw = `FCR_RST_SPEED;
      next_dup_wr = `FCR_RST_DUPLEX;
      next_dup = `FCR_RST_DUPLEX;
      next_restart = 1'b0;
      next_brk = 1'b0;
      next_spd_q = 2'h0;
    end
  end

  // Register all state
  always_ff @(posedge clk_i) begin
    state <= next_state;
    cnt <= next_cnt;
    loop <= next_loop;
    an_en <= next_an_en;
    powerdown_strap <= next_powerdown_strap;
    spd_rw <= next_spd_rw;
    dup_wr <= next_dup_wr;
    dup <= next_dup;
    restart <= next_restart;
    brk <= next_brk;
    rst_q <= next_rst_q;
    spd_q <= next_spd_q;
    ack <= next_ack;
    rdat <= next_rdat;
  end

  // Loopback control toward the data path
  always_comb begin
    lb_if.loop_en = loop;
    lb_if.link_hold = brk | powerdown_strap | (state == fcr_st_swrst);
    // RULE5: rate follows mode
    unique case (mode)
      `FCR_MODE_FX: lb_if.lb_rate = fcr_spd_100;
      `FCR_MODE_BX: lb_if.lb_rate = fcr_spd_1000;
      default: lb_if.lb_rate = spd_q;
    endcase
  end

  // Outputs
  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;
  assign fiber_reset_o = (state == fcr_st_swrst);
  // RULE10: no negotiation in FX
  assign an_restart_o = restart & ~fx_mode;
  assign an_enable_o = an_en & ~fx_mode;
  assign link_break_o = brk & ~fx_mode;
  assign duplex_o = dup;
  assign powerdown_o = powerdown_strap;
  assign speed_o = spd_q;

endmodule : fcr_top

// ### pkg/fcr_consts.svh
`ifndef FCR_CONSTS_SVH
`define FCR_CONSTS_SVH

// Register map, word offsets on the bus
`define FCR_ADR_CTRL 6'h00

// Control register field positions
`define FCR_B_SWRST 15
`define FCR_B_LOOP 14
`define FCR_B_SPD_LSB 13
`define FCR_B_ANEN 12
`define FCR_B_POWERDOWN_STRAP 11
`define FCR_B_ISO 10
`define FCR_B_RESTART 9
`define FCR_B_DUPLEX 8
`define FCR_B_COLT 7
`define FCR_B_SPD_MSB 6

// Hardware reset values
`define FCR_RST_LOOP 1'h0
`define FCR_RST_DUPLEX 1'h1
`define FCR_RST_SPEED 2'h2

// Media operating select, low two bits
`define FCR_MODE_FX 2'h0
`define FCR_MODE_BX 2'h1
`define FCR_MODE_SG 2'h2
`define FCR_MODE_RW 2'h3

// Timing: clock rate and software reset duration
`define FCR_CLK_MHZ 40
`define FCR_SWRST_NS 100
`define FCR_SWRST_CYC ((`FCR_SWRST_NS * `FCR_CLK_MHZ + 999) / 1000)
`define FCR_CNT_W 4

`endif

// ### pkg/fcr_lb_if.sv
`timescale 1ns/1ps
// Control from the register bank to the data path
interface fcr_lb_if;
  logic loop_en; // Loopback active
  logic link_hold; // Force line link down
  logic [1:0] lb_rate; // Loopback rate code

  modport ctl (output loop_en, output link_hold, output lb_rate);
  modport dp (input loop_en, input link_hold, input lb_rate);
endinterface : fcr_lb_if

// ### pkg/fcr_pkg.sv
package fcr_pkg;

  // Speed code as seen in the two speed bits
  typedef enum logic [1:0] {
    fcr_spd_10 = 2'h0,
    fcr_spd_100 = 2'h1,
    fcr_spd_1000 = 2'h2
  } fcr_speed_t;

  // Fiber-side reset sequencer
  typedef enum logic {
    fcr_st_run,
    fcr_st_swrst
  } fcr_state_t;

endpackage : fcr_pkg

// ### sim/fcr_asserts.sv
`timescale 1ns/1ps
`include "fcr_consts.svh"
// Port-side checks for the fiber control block
module fcr_asserts
  import fcr_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic [2:0] op_sel_i, // Media select
  input wire logic [7:0] host_txd_i, // Transmit data
  input wire logic host_tx_en_i, // Transmit enable
  input wire logic line_rx_dv_i, // Line receive valid
  input wire logic [7:0] host_rxd_o, // Receive data
  input wire logic host_rx_dv_o, // Receive valid
  input wire logic [7:0] line_txd_o, // Line transmit data
  input wire logic line_tx_en_o, // Line transmit enable
  input wire logic link_up_o, // Reported link
  input wire logic [1:0] loop_rate_o, // Loopback rate
  input wire logic fiber_reset_o, // Reset busy
  input wire logic an_restart_o, // Restart pulse
  input wire logic an_enable_o, // Effective enable
  input wire logic link_break_o, // Break pulse
  input wire logic [1:0] speed_o // Effective speed
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Accepted write that sets the reset bit
  sequence s_rst_wr;
    wb_ack_o && wb_cyc_i && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[1] && wb_dat_i[`FCR_B_SWRST];
  endsequence
  // Busy for several cycles, then released
  sequence s_busy;
    fiber_reset_o [*3] ##[1:3] !fiber_reset_o;
  endsequence
  chk_swrst_busy: assert property (s_rst_wr |=> s_busy) else $error("reset busy span wrong");
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  chk_ack_time: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_ro_zero: assert property (wb_ack_o && !wb_we_i |-> (wb_dat_o & 32'hFFFF04BF) == 32'h0)
    else $error("read-only bits not zero");
  chk_loop_data: assert property (host_rx_dv_o && !$past(line_rx_dv_i) |-> host_rxd_o == $past(host_txd_i))
    else $error("looped data wrong");
  chk_tx_path: assert property (line_tx_en_o |-> $past(host_tx_en_i) && line_txd_o == $past(host_txd_i))
    else $error("line transmit wrong");
  chk_break_pair: assert property (link_break_o |-> an_restart_o ##1 !link_up_o)
    else $error("break without restart");
  chk_fx_quiet: assert property ((op_sel_i[1:0] == `FCR_MODE_FX) [*2] |-> !an_enable_o && !link_break_o)
    else $error("negotiation active in FX");
  chk_fx_rate: assert property ((op_sel_i[1:0] == `FCR_MODE_FX) [*3] |-> loop_rate_o == 2'h1 && speed_o == 2'h1)
    else $error("FX rate wrong");
  chk_bx_rate: assert property ((op_sel_i[1:0] == `FCR_MODE_BX) [*3] |-> loop_rate_o == 2'h2 && speed_o == 2'h2)
    else $error("BX rate wrong");
endmodule : fcr_asserts

bind fcr_top fcr_asserts chk_u (.*);

// ### sim/tb.sv
`timescale 1ns/1ps
`include "fcr_consts.svh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin n_errors++; $display("unexpected %s exp %h got %h", n, e, a); end end
// Self-checking bench for the fiber control block
module tb;
  import fcr_pkg::*;
  logic clk_i = 1'b0; // Clock
  logic rst_i = 1'b1; // Reset
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus controls
  logic [7:0] adr = 8'h00; // Bus address
  logic [3:0] sel = 4'h0; // Byte enables
  logic [31:0] dat_w = 32'h0, rdat, rd; // Bus data
  logic an_s = 1'b1, pd_s = 1'b0; // Straps
  logic [2:0] op = 3'h3; // Media select
  logic [1:0] live = 2'h0; // Live speed
  logic [7:0] txd = 8'h00; // Transmit data
  logic tx_en = 1'b0; // Transmit enable
  logic ack, rx_dv, ltx_en, link_up, frst, anrs, anen, brk, dup, pdn; // Outputs
  logic [7:0] rxd, ltxd; // Output data
  logic [1:0] lrate, spd; // Output codes
  int n_errors = 0, num_checks = 0, n_brk = 0, n_rs = 0; // Counters
  fcr_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(rdat), .wb_ack_o(ack),
    .autoneg_strap_i(an_s), .powerdown_strap_i(pd_s), .op_sel_i(op), .live_speed_i(live),
    .host_txd_i(txd), .host_tx_en_i(tx_en), .line_rxd_i(8'h3C), .line_rx_dv_i(1'b0), .line_link_i(1'b1),
    .host_rxd_o(rxd), .host_rx_dv_o(rx_dv), .line_txd_o(ltxd), .line_tx_en_o(ltx_en), .link_up_o(link_up),
    .loop_rate_o(lrate), .fiber_reset_o(frst), .an_restart_o(anrs), .an_enable_o(anen),
    .link_break_o(brk), .duplex_o(dup), .powerdown_o(pdn), .speed_o(spd));
  // 40 MHz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // Pulse counters, sampled mid-cycle to stay clear of the edge
  always @(negedge clk_i) begin
    if (brk === 1'b1) n_brk++;
    if (anrs === 1'b1) n_rs++;
  end
  // Verdict and end of run
  task conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // One classic bus cycle, waiting on ack under a bound
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h3; dat_w <= d;
    do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 20);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (k >= 20) begin n_errors++; $display("unexpected ack timeout"); conclude(); end
  endtask : bus
  // Read the control word and compare
  task rdchk(input string n, input logic [15:0] e);
    bus(1'b0, 8'h00, 32'h0);
    `CHK(n, {16'h0, e}, rd)
  endtask : rdchk
  // Hardware reset with given straps and select
  task do_reset(input logic a, input logic p, input logic [2:0] o);
    rst_i <= 1'b1; an_s <= a; pd_s <= p; op <= o;
    repeat (10) @(posedge clk_i);
    n_rs = 0;
    n_brk = 0;
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : do_reset
  // Reset values and an unmapped word
  task t_reset_vals;
    do_reset(1'b1, 1'b0, 3'h3);
    `CHK("hw_restart", 1, n_rs)
    `CHK("duplex", 1'b1, dup)
    rdchk("ctrl", 16'h1140);
    bus(1'b1, 8'h04, 32'hFFFF);
    bus(1'b0, 8'h04, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    rdchk("ctrl2", 16'h1140);
  endtask : t_reset_vals
  // Field writes, enable change and loopback data
  task t_fields;
    // Loopback, speed 01, enable off, duplex half; isolate, collision test and reserved bits written as ones
    bus(1'b1, 8'h00, 32'h64BF);
    repeat (3) @(posedge clk_i);
    `CHK("break", 1, n_brk)
    `CHK("restart", 2, n_rs)
    `CHK("dup_apply", 1'b0, dup)
    `CHK("speed_rw", 2'h1, spd)
    rdchk("ctrl", 16'h6000);
    txd <= 8'hA5;
    tx_en <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK("lb_dv", 1'b1, rx_dv)
    `CHK("lb_data", 8'hA5, rxd)
    `CHK("line_tx", 1'b0, ltx_en)
    `CHK("link", 1'b0, link_up)
    tx_en <= 1'b0;
  endtask : t_fields
  // Software reset wins over loopback, then clears itself
  task t_swrst;
    int r0;
    r0 = n_rs;
    bus(1'b1, 8'h00, 32'hE000);
    rdchk("busy", 16'hA000);
    `CHK("fiber_rst", 1'b1, frst)
    repeat (8) @(posedge clk_i);
    rdchk("done", 16'h2000);
    `CHK("fiber_idle", 1'b0, frst)
    `CHK("sw_restart", r0 + 1, n_rs)
    `CHK("dup_keep", 1'b0, dup)
    // Loopback cleared by the reset: transmit goes to the line again
    txd <= 8'h5A;
    tx_en <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK("line_tx_on", 1'b1, ltx_en)
    `CHK("line_txd", 8'h5A, ltxd)
    `CHK("no_loop_dv", 1'b0, rx_dv)
    `CHK("link_back", 1'b1, link_up)
    tx_en <= 1'b0;
  endtask : t_swrst
  // Duplex deferred until a restart
  task t_duplex;
    int r0;
    r0 = n_rs;
    bus(1'b1, 8'h00, 32'h2100);
    repeat (3) @(posedge clk_i);
    `CHK("dup_held", 1'b0, dup)
    `CHK("no_restart", r0, n_rs)
    bus(1'b1, 8'h00, 32'h2300);
    repeat (3) @(posedge clk_i);
    `CHK("dup_set", 1'b1, dup)
    `CHK("wr_restart", r0 + 1, n_rs)
    rdchk("self_clr", 16'h2100);
  endtask : t_duplex
  // Power-down exit forces reset and restart
  task t_powerdown_strap;
    int r0;
    bus(1'b1, 8'h00, 32'h2900);
    repeat (3) @(posedge clk_i);
    `CHK("pd_on", 1'b1, pdn)
    r0 = n_rs;
    bus(1'b1, 8'h00, 32'h2100);
    rdchk("pd_exit", 16'hA100);
    repeat (8) @(posedge clk_i);
    `CHK("pd_restart", 1'b1, n_rs > r0)
    `CHK("pd_off", 1'b0, pdn)
  endtask : t_powerdown_strap
  // Speed bits and loop rate across media selects
  task t_modes;
    logic [2:0] om[4] = '{3'h0, 3'h1, 3'h2, 3'h2};
    logic [1:0] lv[4] = '{2'h0, 2'h0, 2'h1, 2'h2};
    logic [1:0] ex[4] = '{2'h1, 2'h2, 2'h1, 2'h2};
    int b0;
    for (int i = 0; i < 4; i++) begin
      op <= om[i];
      live <= lv[i];
      repeat (4) @(posedge clk_i);
      rdchk("spd_bits", {2'h0, ex[i][0], 6'h02, ex[i][1], 6'h00});
      `CHK("speed", ex[i], spd)
      if (i < 2) `CHK("rate", ex[i], lrate)
    end
    op <= 3'h0;
    repeat (3) @(posedge clk_i);
    b0 = n_brk;
    bus(1'b1, 8'h00, 32'h1100);
    repeat (3) @(posedge clk_i);
    `CHK("fx_break", b0, n_brk)
    `CHK("fx_enable", 1'b0, anen)
  endtask : t_modes
  // Strap loading at hardware reset
  task t_strap;
    do_reset(1'b0, 1'b1, 3'h4);
    rdchk("strap_100", 16'h2900);
    `CHK("pd_strap", 1'b1, pdn)
    do_reset(1'b0, 1'b1, 3'h0);
    rdchk("strap_000", 16'h2100);
    do_reset(1'b1, 1'b1, 3'h3);
    rdchk("strap_011", 16'h1940);
  endtask : t_strap
  // Main sequence
  initial begin
    t_reset_vals;
    t_fields;
    t_swrst;
    t_duplex;
    t_powerdown_strap;
    t_modes;
    t_strap;
    conclude;
  end
endmodule : tb
